// ==== logic/nbac_pkg.sv ====
package nbac_pkg;

	// Register locations on the special function register port.
	localparam logic [7:0] NBAC_CTRL_OFS = 8'h40;
	localparam logic [1:0] NBAC_CTRL_BANK = 2'h1;
	localparam logic [7:0] NBAC_ADDR_OFS = 8'h1E;
	localparam logic [7:0] NBAC_BUF_OFS = 8'h1F;
	localparam logic [7:0] NBAC_BANK_OFS = 8'h04;
	localparam logic [7:0] NBAC_IRQ_OFS = 8'h1D;

	// Control register field positions.
	localparam int NBAC_RD_BIT = 0;
	localparam int NBAC_FETCH_ENABLE_BIT_BIT = 1;
	localparam int NBAC_WR_BIT = 2;
	localparam int NBAC_STORE_ENABLE_BIT_BIT = 3;

	// Interrupt control register field positions.
	localparam int NBAC_IRQEN_BIT = 0;
	localparam int NBAC_IRQFLAG_BIT = 1;

	// Widths and reset values.
	localparam int NBAC_AW = 6;
	localparam int NBAC_DEPTH = 64;
	localparam logic [7:0] NBAC_BUF_RST = 8'h00;
	localparam logic [1:0] NBAC_BANK_RST = 2'h0;

	// Cycle timing.
	localparam logic [15:0] NBAC_READ_CYCLES = 16'h0002;
	localparam logic [15:0] NBAC_WRITE_CYCLES_DEF = 16'h03E8;

	// Array cycle sequencer states, Gray coded along idle-read-write.
	typedef enum logic [1:0]
	{
		NBAC_IDLE = 2'b00,
		NBAC_READ = 2'b01,
		NBAC_WRITE = 2'b11
	} nbac_state_t;

endpackage

// ==== logic/nbac_core.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Array reads and writes are single bytes via address, buffer and control registers.
// - Control register sits at 40H of bank 1, reached only indirectly.
// - Address register holds six bits; top two read zero; no reset value, though the code resets it to zero.
// - Byte buffer is eight bits read/write, cleared at power-on.
// - Control: store enable bit3, write trigger bit2, fetch enable bit1, read trigger bit0.
// - With store enable clear, no array write happens.
// - With fetch enable clear, no array read happens.
// - Write trigger set without store enable already set starts nothing.
// - Read trigger set without fetch enable already set starts nothing.
// - Hardware clears read trigger at read end; buffer then holds fetched byte.
// - Read result stays in the buffer until a later read or write.
// - Hardware clears write trigger once the byte has been stored.
// - Write cycle is timed by an internal timer independent of software.
// - Power-on clears store enable and resets bank select to zero.
// - Each write cycle end sets the completion interrupt flag, except a write abandoned by clearing store enable.
// - Interrupt vectors only with local and global enable set and stack not full.
// - Servicing the interrupt clears the completion flag automatically.
module nbac_core
	import nbac_pkg::*;
#(
	parameter logic [15:0] WRITE_CYCLES = NBAC_WRITE_CYCLES_DEF
)
(
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// Special function register port, same clock as the processor.
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_indirect_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	// Interrupt controller side.
	input wire logic global_irq_enable_in,
	input wire logic stack_full_in,
	input wire logic irq_service_in,
	output logic irq_request_out,
	// Status.
	output logic [1:0] bank_select_out,
	output logic busy_out
);

	////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed
	{
		nbac_state_t state;
		logic [15:0] count;
		logic [NBAC_AW-1:0] address;
		logic [7:0] byte_buffer;
		logic store_enable_bit;
		logic write_trig;
		logic fetch_enable_bit;
		logic read_trig;
		logic [1:0] bank_select;
		logic nvm_irq_enable;
		logic nvm_irq_flag;
		logic irq_req;
		logic [NBAC_AW-1:0] lat_addr;
		logic [7:0] lat_data;
		logic [7:0] rdata;
	} nbac_regs_t;

	nbac_regs_t r_reg;
	nbac_regs_t r_next;
	logic [7:0] mem [NBAC_DEPTH];
	logic mem_we;
	logic [7:0] mem_rd;
	logic rst_s1_reg;
	logic rst_s2_reg;
	logic hit_ctrl;
	logic hit_addr;
	logic hit_buf;
	logic hit_bank;
	logic hit_irq;
	logic [7:0] ctrl_view;

	////////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops; assertion stays asynchronous.

	always_ff @(posedge ref_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Decode. Direct access always lands in bank 0, so the control register
	// can only be hit through the indirect port with bank 1 selected.

	always_comb
	begin
		hit_ctrl = sfr_indirect_in && (r_reg.bank_select == NBAC_CTRL_BANK)
			&& (sfr_addr_in == NBAC_CTRL_OFS);
		hit_addr = sfr_addr_in == NBAC_ADDR_OFS;
		hit_buf = sfr_addr_in == NBAC_BUF_OFS;
		hit_bank = sfr_addr_in == NBAC_BANK_OFS;
		hit_irq = sfr_addr_in == NBAC_IRQ_OFS;
	end

	// Control register image; upper nibble reads zero.
	always_comb
	begin
		ctrl_view = 8'h00;
		ctrl_view[NBAC_STORE_ENABLE_BIT_BIT] = r_reg.store_enable_bit;
		ctrl_view[NBAC_WR_BIT] = r_reg.write_trig;
		ctrl_view[NBAC_FETCH_ENABLE_BIT_BIT] = r_reg.fetch_enable_bit;
		ctrl_view[NBAC_RD_BIT] = r_reg.read_trig;
	end

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb
	begin
		r_next = r_reg;
		mem_we = 1'b0;

		// Software writes to the plain registers.
		if (sfr_wr_in && hit_addr)
		begin
			r_next.address = sfr_wdata_in[NBAC_AW-1:0];
		end
		if (sfr_wr_in && hit_buf)
		begin
			r_next.byte_buffer = sfr_wdata_in;
		end
		if (sfr_wr_in && hit_bank)
		begin
			r_next.bank_select = sfr_wdata_in[1:0];
		end
		if (sfr_wr_in && hit_irq)
		begin
			r_next.nvm_irq_enable = sfr_wdata_in[NBAC_IRQEN_BIT];
			r_next.nvm_irq_flag = sfr_wdata_in[NBAC_IRQFLAG_BIT];
		end

		// Control writes. A trigger only takes when its enable was already set
		// before this write; triggers cannot be cleared by software mid-cycle,
		// and a request for both triggers at once is ignored.
		if (sfr_wr_in && hit_ctrl)
		begin
			r_next.store_enable_bit = sfr_wdata_in[NBAC_STORE_ENABLE_BIT_BIT];
			r_next.fetch_enable_bit = sfr_wdata_in[NBAC_FETCH_ENABLE_BIT_BIT];
			if (r_reg.state == NBAC_IDLE
				&& !(sfr_wdata_in[NBAC_WR_BIT] && sfr_wdata_in[NBAC_RD_BIT]))
			begin
				if (sfr_wdata_in[NBAC_WR_BIT] && r_reg.store_enable_bit)
				begin
					r_next.write_trig = 1'b1;
					r_next.state = NBAC_WRITE;
					r_next.count = WRITE_CYCLES;
					r_next.lat_addr = r_reg.address;
					r_next.lat_data = (hit_buf) ? sfr_wdata_in : r_reg.byte_buffer;
				end
				else if (sfr_wdata_in[NBAC_RD_BIT] && r_reg.fetch_enable_bit)
				begin
					r_next.read_trig = 1'b1;
					r_next.state = NBAC_READ;
					r_next.count = NBAC_READ_CYCLES;
					r_next.lat_addr = r_reg.address;
				end
			end
		end

		// Array cycle sequencer.
		unique case (r_reg.state)
			NBAC_IDLE:
			begin
			end
			NBAC_READ:
			begin
				if (!r_next.fetch_enable_bit)
				begin
					// Fetch enable dropped: abandon, buffer untouched.
					r_next.read_trig = 1'b0;
					r_next.state = NBAC_IDLE;
				end
				else if (r_reg.count == 16'h0001)
				begin
					r_next.byte_buffer = mem_rd;
					r_next.read_trig = 1'b0;
					r_next.state = NBAC_IDLE;
				end
				else
				begin
					r_next.count = r_reg.count - 16'h0001;
				end
			end
			NBAC_WRITE:
			begin
				if (!r_next.store_enable_bit)
				begin
					// Store enable dropped: nothing is stored, no completion event.
					r_next.write_trig = 1'b0;
					r_next.state = NBAC_IDLE;
				end
				else if (r_reg.count <= 16'h0001)
				begin
					mem_we = 1'b1;
					r_next.write_trig = 1'b0;
					r_next.nvm_irq_flag = 1'b1;
					r_next.state = NBAC_IDLE;
				end
				else
				begin
					r_next.count = r_reg.count - 16'h0001;
				end
			end
		endcase

		// Servicing clears the flag, but a completion in the same cycle wins.
		if (irq_service_in && !mem_we)
		begin
			r_next.nvm_irq_flag = 1'b0;
		end
		r_next.irq_req = r_reg.nvm_irq_flag && r_reg.nvm_irq_enable
			&& global_irq_enable_in && !stack_full_in && !irq_service_in;

		// Registered read data, one cycle behind the address.
		if (hit_ctrl)
		begin
			r_next.rdata = ctrl_view;
		end
		else if (hit_addr)
		begin
			r_next.rdata = {2'b00, r_reg.address};
		end
		else if (hit_buf)
		begin
			r_next.rdata = r_reg.byte_buffer;
		end
		else if (hit_bank)
		begin
			r_next.rdata = {6'h00, r_reg.bank_select};
		end
		else if (hit_irq)
		begin
			r_next.rdata = {6'h00, r_reg.nvm_irq_flag, r_reg.nvm_irq_enable};
		end
		else
		begin
			r_next.rdata = 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register. The address has no defined power-on value but is given
	// zero here so simulation stays free of unknowns.

	always_ff @(posedge ref_clk_in or negedge rst_s2_reg)
	begin
		if (!rst_s2_reg)
		begin
			r_reg <= '0;
			r_reg.state <= NBAC_IDLE;
			r_reg.byte_buffer <= NBAC_BUF_RST;
			r_reg.store_enable_bit <= 1'b0;
			r_reg.bank_select <= NBAC_BANK_RST;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// Array storage; no reset, contents are retained.
	always_ff @(posedge ref_clk_in)
	begin
		if (mem_we)
		begin
			mem[r_reg.lat_addr] <= r_reg.lat_data;
		end
	end

	assign mem_rd = mem[r_reg.lat_addr];

	////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign sfr_rdata_out = r_reg.rdata;
	assign irq_request_out = r_reg.irq_req;
	assign bank_select_out = r_reg.bank_select;
	assign busy_out = r_reg.state != NBAC_IDLE;

endmodule // nbac_core

// ==== test/nbac_monitor.sv ====
`timescale 1ns/1ps
module nbac_monitor
	import nbac_pkg::*;
#(
	parameter logic [15:0] WRITE_CYCLES = NBAC_WRITE_CYCLES_DEF
)
(
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// Register port.
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_indirect_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic [7:0] sfr_rdata_out,
	// Interrupt and status.
	input wire logic global_irq_enable_in,
	input wire logic stack_full_in,
	input wire logic irq_service_in,
	input wire logic irq_request_out,
	input wire logic [1:0] bank_select_out,
	input wire logic busy_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	////////////////////////////////////////
	// Busy run length; the run kind is latched while idle, so it holds the trigger seen before busy rose.
	// A write cut short by clearing store enable is remembered, since its run is legally short.
	logic [15:0] run_reg;
	logic wr_run_reg;
	logic cut_reg;
	always_ff @(posedge ref_clk_in)
	begin
		run_reg <= busy_out ? run_reg + 16'h0001 : 16'h0000;
		if (!busy_out)
		begin
			wr_run_reg <= sfr_wr_in & sfr_wdata_in[NBAC_WR_BIT];
			cut_reg <= 1'b0;
		end
		else if (wr_run_reg && sfr_wr_in && sfr_indirect_in && bank_select_out == NBAC_CTRL_BANK
			&& sfr_addr_in == NBAC_CTRL_OFS && !sfr_wdata_in[NBAC_STORE_ENABLE_BIT_BIT])
		begin
			cut_reg <= 1'b1;
		end
	end
	////////////////////////////////////////
	// Steps of a cycle start.
	sequence s_ctrl_hit;
		sfr_indirect_in && bank_select_out == NBAC_CTRL_BANK && sfr_addr_in == NBAC_CTRL_OFS;
	endsequence
	sequence s_rd_start;
		$rose(busy_out) && !wr_run_reg;
	endsequence
	chk_direct_ctrl: assert property (!sfr_indirect_in && sfr_addr_in == NBAC_CTRL_OFS
		|=> sfr_rdata_out == 8'h00)
		else $error("direct control read not zero");
	chk_ctrl_upper: assert property (s_ctrl_hit |=> sfr_rdata_out[7:4] == 4'h0)
		else $error("control upper bits set");
	chk_addr_upper: assert property (sfr_addr_in == NBAC_ADDR_OFS |=> sfr_rdata_out[7:6] == 2'h0)
		else $error("address upper bits set");
	chk_bank_read: assert property (sfr_addr_in == NBAC_BANK_OFS && !sfr_wr_in
		|=> sfr_rdata_out == {6'h00, bank_select_out})
		else $error("bank read differs");
	chk_busy_cause: assert property ($rose(busy_out) |-> $past(sfr_wr_in) && $past(sfr_indirect_in))
		else $error("busy without trigger write");
	chk_read_len: assert property (s_rd_start |=> busy_out ##1 !busy_out)
		else $error("read length wrong");
	chk_write_len: assert property ($fell(busy_out) && wr_run_reg && !cut_reg
		|-> run_reg + 16'h0001 >= WRITE_CYCLES && run_reg <= WRITE_CYCLES + 16'h0001)
		else $error("write length wrong");
	chk_write_cut: assert property (cut_reg |-> !busy_out)
		else $error("cut write still busy");
	chk_irq_gate: assert property (irq_request_out |-> $past(global_irq_enable_in) && !$past(stack_full_in))
		else $error("request while gated");
endmodule // nbac_monitor

bind nbac_core nbac_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (.ref_clk_in, .rst_b_in, .sfr_addr_in,
	.sfr_indirect_in, .sfr_wr_in, .sfr_wdata_in, .sfr_rdata_out, .global_irq_enable_in, .stack_full_in,
	.irq_service_in, .irq_request_out, .bank_select_out, .busy_out);

// ==== test/nbac_core_tb.sv ====
`timescale 1ns/1ps
module nbac_core_tb
	import nbac_pkg::*;
;
	// Short write time keeps the run brief.
	localparam logic [15:0] WR_CYC = 16'h000A;
	logic ref_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] sfr_addr_in = 8'h00;
	logic sfr_indirect_in = 1'b0;
	logic sfr_wr_in = 1'b0;
	logic [7:0] sfr_wdata_in = 8'h00;
	logic global_irq_enable_in = 1'b0;
	logic stack_full_in = 1'b0;
	logic irq_service_in = 1'b0;
	logic [7:0] sfr_rdata_out;
	logic irq_request_out;
	logic [1:0] bank_select_out;
	logic busy_out;
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;
	nbac_core #(.WRITE_CYCLES(WR_CYC)) uut (.ref_clk_in, .rst_b_in, .sfr_addr_in, .sfr_indirect_in, .sfr_wr_in,
		.sfr_wdata_in, .sfr_rdata_out, .global_irq_enable_in, .stack_full_in, .irq_service_in, .irq_request_out,
		.bank_select_out, .busy_out);
	////////////////////////////////////////
	// Clock and hang guard.
	initial forever #5 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fails++;
			conclude();
		end
	end
	////////////////////////////////////////
	// Shared access and compare tasks; inputs move only at the falling edge.
	task automatic conclude();
		if (fails == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask
	task automatic put(input logic [7:0] a, input logic ind, input logic [7:0] d);
		@(negedge ref_clk_in);
		sfr_addr_in = a;
		sfr_indirect_in = ind;
		sfr_wdata_in = d;
		sfr_wr_in = 1'b1;
		@(negedge ref_clk_in);
		sfr_wr_in = 1'b0;
	endtask
	task automatic ctrl(input logic [7:0] d);
		put(NBAC_CTRL_OFS, 1'b1, d);
	endtask
	task automatic get(input string what, input logic [7:0] a, input logic ind, input logic [7:0] exp);
		@(negedge ref_clk_in);
		sfr_addr_in = a;
		sfr_indirect_in = ind;
		@(negedge ref_clk_in);
		check(what, exp, sfr_rdata_out);
	endtask
	task automatic wait_idle();
		for (int n = 0; n < 40 && busy_out !== 1'b0; n++)
			@(negedge ref_clk_in);
		check("busy", 8'h00, {7'h00, busy_out});
	endtask
	////////////////////////////////////////
	// Scenarios.
	task automatic t_reset();
		get("bank", NBAC_BANK_OFS, 1'b0, 8'h00);
		get("buffer", NBAC_BUF_OFS, 1'b0, 8'h00);
		put(NBAC_BANK_OFS, 1'b0, 8'h01);
		check("bank pin", 8'h01, {6'h00, bank_select_out});
		get("ctrl", NBAC_CTRL_OFS, 1'b1, 8'h00);
	endtask
	task automatic t_refuse();
		put(NBAC_CTRL_OFS, 1'b0, 8'h08);
		ctrl(8'h04);
		ctrl(8'h01);
		get("refused", NBAC_CTRL_OFS, 1'b1, 8'h00);
	endtask
	task automatic t_write();
		put(NBAC_IRQ_OFS, 1'b0, 8'h01);
		stack_full_in = 1'b1;
		put(NBAC_ADDR_OFS, 1'b0, 8'hFF);
		get("address", NBAC_ADDR_OFS, 1'b0, 8'h3F);
		put(NBAC_BUF_OFS, 1'b0, 8'hA5);
		get("direct", NBAC_CTRL_OFS, 1'b0, 8'h00);
		ctrl(8'h08);
		ctrl(8'h0C);
		global_irq_enable_in = 1'b1;
		get("writing", NBAC_CTRL_OFS, 1'b1, 8'h0C);
		wait_idle();
		get("written", NBAC_CTRL_OFS, 1'b1, 8'h08);
		check("stack full", 8'h00, {7'h00, irq_request_out});
		stack_full_in = 1'b0;
		repeat (2) @(negedge ref_clk_in);
		check("request", 8'h01, {7'h00, irq_request_out});
		irq_service_in = 1'b1;
		@(negedge ref_clk_in);
		irq_service_in = 1'b0;
		get("serviced", NBAC_IRQ_OFS, 1'b0, 8'h01);
	endtask
	// Cut a write short by clearing store enable; the later fetch of the same byte proves nothing was stored.
	task automatic t_cut();
		put(NBAC_BUF_OFS, 1'b0, 8'h5A);
		ctrl(8'h08);
		ctrl(8'h0C);
		repeat (3) @(negedge ref_clk_in);
		ctrl(8'h00);
		get("cut ctrl", NBAC_CTRL_OFS, 1'b1, 8'h00);
		check("cut busy", 8'h00, {7'h00, busy_out});
		check("cut request", 8'h00, {7'h00, irq_request_out});
		get("cut flag", NBAC_IRQ_OFS, 1'b0, 8'h01);
	endtask
	task automatic t_read();
		put(NBAC_BUF_OFS, 1'b0, 8'h77);
		ctrl(8'h00);
		ctrl(8'h01);
		get("no fetch", NBAC_BUF_OFS, 1'b0, 8'h77);
		ctrl(8'h04);
		ctrl(8'h02);
		ctrl(8'h03);
		wait_idle();
		get("fetch done", NBAC_CTRL_OFS, 1'b1, 8'h02);
		get("fetched", NBAC_BUF_OFS, 1'b0, 8'hA5);
		get("kept", NBAC_BUF_OFS, 1'b0, 8'hA5);
	endtask
	////////////////////////////////////////
	// Main sequence.
	initial
	begin
		repeat (6) @(negedge ref_clk_in);
		rst_b_in = 1'b1;
		repeat (3) @(negedge ref_clk_in);
		t_reset();
		t_refuse();
		t_write();
		t_cut();
		t_read();
		conclude();
	end
endmodule // nbac_core_tb
